// ---- logic/reset_state_controller.sv ----
/*
 * Reset sequencer and initial-state logic: sorts reset causes, sets
 * status and reset flags, presets core registers, holds internal reset.
 * Assumes power-on arrives as RST, low voltage as a synchronous level,
 * and software reaches the registers over classic Wishbone.
 * A stand-in program counter runs between resets so that clears show.
 */
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_map.svh"
module reset_state_controller
   import reset_state_pkg::*;
#(
   parameter int RSTD_CYCLES = `RSTD_CYC,
   parameter int SST_CYCLES  = `SST_CYC
)
(
   // clock and power-on reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // reset sources
   input  wire logic        LOW_VOLTAGE,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [3:0]  WB_SEL_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   // core state outputs
   output logic             CORE_RESET,
   output logic [12:0]      PROGRAM_COUNTER,
   output logic [2:0]       STACK_POINTER,
   output logic             INT_ENABLE,
   output logic [7:0]       TIMER_CTRL,
   output logic [7:0]       PORT_A_DATA,
   output logic [7:0]       PORT_A_DIRECTION,
   output logic [7:0]       PORT_A_PULLUP,
   // interrupt
   output logic             IRQ
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // every register of the block in one struct; s_d is its next value
   typedef struct packed {
      seq_state_t  seq;          // sequencer state
      logic        to_flag;      // watchdog_timeout_flag
      logic        pd_flag;      // power_down_flag
      logic        lvr_flag;     // low_voltage_reset_flag
      logic        wrf_flag;     // watchdog_write_reset_flag
      logic [7:0]  wdog_ctrl;    // watchdog_control_register
      logic        sleep;        // sleep/idle mode
      logic [2:0]  irq_stat;     // sticky events
      logic [2:0]  irq_mask;     // event mask
      logic        lv_prev;      // low-voltage edge detect
      logic [7:0]  accumulator;  // preserved except power-on
      logic [7:0]  table_pointer;
      logic        core_rst;
      logic [12:0] pc;
      logic [2:0]  sp;
      logic        int_en;
      logic [7:0]  timer;
      logic [7:0]  pa;
      logic [7:0]  pa_dir;
      logic [7:0]  pa_pu;
      logic [31:0] dat;
      logic        ack;
      logic        irq;
      logic        por_pend;     // power-on hold still to be armed
   } ctl_state_t;
   ctl_state_t s_q;
   ctl_state_t s_d;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   logic        wd_timeout;    // watchdog overflow
   logic        wd_bad;        // enable field illegal
   logic        dly_busy;      // hold/wake counter running
   logic        dly_load;      // start delay
   logic [15:0] dly_count;     // delay length
   logic        wd_clear;      // clear watchdog
   logic        wb_req;        // new bus request
   logic        wb_wr;         // write strobe
   logic        lv_event;      // qualified low-voltage reset
   reset_kind_t kind;          // reset selected this cycle
   logic [2:0]  irq_ev;        // events raised this cycle

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // causes that preset the whole core, unlike the wake from sleep
   function automatic logic is_full_reset(input reset_kind_t k);
      return (k == RK_LOW_VOLT) || (k == RK_WDOG_RUN) || (k == RK_WDOG_WRITE);
   endfunction

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   // a request is taken only while ack is low, so a master that holds
   // its strobe through the ack cycle is answered exactly once
   assign wb_req = WB_CYC_I && WB_STB_I && !s_q.ack;
   // only lane 0 carries register bits, so it alone gates a write
   assign wb_wr  = wb_req && WB_WE_I && WB_SEL_I[0];

   // the supply monitor is off in sleep: an edge there is dropped, and
   // the detector keeps tracking the pin so no stale edge shows on wake
   // ignore in sleep
   assign lv_event = LOW_VOLTAGE && !s_q.lv_prev && !s_q.sleep;

   // priority: low voltage, then watchdog events
   // a failing supply outranks everything; a bad enable field is only
   // acted on while running, so the preset it causes cannot retrigger
   always_comb begin
      kind = RK_NONE;
      if (lv_event) begin
         kind = RK_LOW_VOLT;
      end else if (wd_bad && s_q.seq == ST_RUN) begin
         kind = RK_WDOG_WRITE;
      end else if (wd_timeout && s_q.sleep) begin
         kind = RK_WDOG_SLEEP;
      end else if (wd_timeout) begin
         kind = RK_WDOG_RUN;
      end
   end

   // kicks, every reset cause and the whole hold restart the count, so a
   // fresh period always begins when the core is let go
   // watchdog cleared on reset
   assign wd_clear  = RST || (kind != RK_NONE) || s_q.core_rst
                      || (wb_wr && WB_ADR_I == `ADDR_CTRL && WB_DAT_I[`CTRL_KICK_BIT]);
   // the counter leaves RST empty, so the power-on hold is loaded on the
   // first edge after release rather than inside the reset branch
   // hold time, wake time
   assign dly_load  = (kind != RK_NONE) || s_q.por_pend;
   assign dly_count = (kind == RK_WDOG_SLEEP) ? 16'(SST_CYCLES) : 16'(RSTD_CYCLES);

   // ---------------------------------------------------------------
   // event vector for the sticky status register
   // ---------------------------------------------------------------
   // bit 0 time-out in either mode, bit 1 write reset, bit 2 low voltage;
   // kept apart so a software clear can never swallow a fresh event
   assign irq_ev[0] = (kind == RK_WDOG_RUN) || (kind == RK_WDOG_SLEEP);
   assign irq_ev[1] = (kind == RK_WDOG_WRITE);
   assign irq_ev[2] = (kind == RK_LOW_VOLT);

   // ---------------------------------------------------------------
   // submodules
   // ---------------------------------------------------------------
   watchdog_core u_wdog (
      .clk          (MCLK),
      .rst          (RST),
      .clear        (wd_clear),
      .enable_field (s_q.wdog_ctrl[7:3]),
      .timeout      (wd_timeout),
      .bad_enable   (wd_bad)
   );

   reset_delay_counter u_dly (
      .clk   (MCLK),
      .rst   (RST),
      .load  (dly_load),
      .count (dly_count),
      .busy  (dly_busy)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // edge detector follows the pin every cycle
      s_d.lv_prev = LOW_VOLTAGE;
      // acknowledge stands for the one cycle after the taking edge
      s_d.ack = wb_req;
      // the power-on hold is armed for exactly one edge
      s_d.por_pend = 1'b0;

      // stand-in for instruction fetch: the counter walks while the core
      // runs, so each clear on reset can be seen; it halts in sleep and
      // while the core is held
      if (s_q.seq == ST_RUN && !s_q.core_rst && !s_q.sleep) begin
         s_d.pc = s_q.pc + 13'h0001;
      end

      // full reset of core registers for run-time resets
      if (is_full_reset(kind)) begin
         s_d.seq       = ST_HOLD;
         s_d.core_rst  = 1'b1;
         s_d.pc        = `PC_RESET;
         s_d.sp        = `SP_RESET;
         s_d.int_en    = 1'b0;
         s_d.timer     = `TIMER_RESET;
         s_d.pa        = `PORT_RESET;
         s_d.pa_dir    = `PORT_RESET;
         s_d.pa_pu     = `PULLUP_RESET;
         s_d.wdog_ctrl = `WDOG_RESET;
         s_d.sleep     = 1'b0;
      end

      unique case (kind)
         RK_LOW_VOLT: begin
            s_d.lvr_flag    = 1'b1;
            s_d.irq_stat[2] = 1'b1;
         end
         RK_WDOG_RUN: begin
            s_d.to_flag     = 1'b1;
            s_d.irq_stat[0] = 1'b1;
         end
         RK_WDOG_WRITE: begin
            s_d.wrf_flag    = 1'b1;
            s_d.irq_stat[1] = 1'b1;
         end
         RK_WDOG_SLEEP: begin
            // timers, ports, interrupts and control keep their values
            // only counter and stack
            s_d.seq      = ST_WAKE;
            s_d.core_rst = 1'b1;
            s_d.pc       = `PC_RESET;
            s_d.sp       = `SP_RESET;
            s_d.to_flag  = 1'b1;
            s_d.pd_flag  = 1'b1;
            s_d.sleep    = 1'b0;
            s_d.irq_stat[0] = 1'b1;
         end
         RK_NONE: begin
            // release once the delay has run out
            // hold and wake share one counter; a new cause reloads it
            if (s_q.seq != ST_RUN && !dly_busy && !s_q.por_pend) begin
               s_d.seq      = ST_RUN;
               s_d.core_rst = 1'b0;
            end
         end
      endcase

      // register writes; hardware sets above win over clears below
      if (wb_wr) begin
         unique case (WB_ADR_I)
            `ADDR_FLAGS: begin
               // only software clears these flags
               if (!WB_DAT_I[`FLAGS_LVR_BIT] && kind != RK_LOW_VOLT) begin
                  s_d.lvr_flag = 1'b0;
               end
               if (!WB_DAT_I[`FLAGS_WRF_BIT] && kind != RK_WDOG_WRITE) begin
                  s_d.wrf_flag = 1'b0;
               end
            end
            `ADDR_WDOG: begin
               if (kind == RK_NONE) begin
                  s_d.wdog_ctrl = WB_DAT_I[7:0];
               end
            end
            `ADDR_IRQ_STAT: begin
               // write one clears; an event in this same cycle wins
               s_d.irq_stat = (s_q.irq_stat & ~WB_DAT_I[2:0]) | irq_ev;
            end
            `ADDR_IRQ_MASK: begin
               s_d.irq_mask = WB_DAT_I[2:0];
            end
            `ADDR_CTRL: begin
               // entering sleep sets the power-down flag
               if (WB_DAT_I[`CTRL_SLEEP_BIT] && kind == RK_NONE) begin
                  s_d.sleep   = 1'b1;
                  s_d.pd_flag = 1'b1;
               end
            end
            default: begin
               // unmapped or read-only: write ignored
            end
         endcase
      end

      // unmapped reads return zero but are still answered
      // read data registered alongside ack
      s_d.dat = 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            `ADDR_STATUS:   s_d.dat = 32'({s_q.to_flag, s_q.pd_flag}) << `STATUS_PDF_BIT;
            `ADDR_FLAGS:    s_d.dat = 32'({s_q.lvr_flag, 1'b0, s_q.wrf_flag});
            `ADDR_WDOG:     s_d.dat = 32'(s_q.wdog_ctrl);
            `ADDR_IRQ_STAT: s_d.dat = 32'(s_q.irq_stat);
            `ADDR_IRQ_MASK: s_d.dat = 32'(s_q.irq_mask);
            `ADDR_CTRL:     s_d.dat = 32'({s_q.core_rst, s_q.sleep});
            default:        s_d.dat = 32'h0000_0000;
         endcase
      end

      // built from next status and mask so it lands together with them
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
   end

   // ---------------------------------------------------------------
   // registers: power-on reset loads every documented initial value
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s_q               <= '0;
         s_q.seq           <= ST_HOLD;
         s_q.core_rst      <= 1'b1;
         s_q.wdog_ctrl     <= `WDOG_RESET;
         s_q.pa            <= `PORT_RESET;
         s_q.pa_dir        <= `PORT_RESET;
         // a high LOW_VOLTAGE level already present at power-on is no new event
         s_q.lv_prev       <= 1'b1;
         // the core stays held; the hold delay loads on the first free edge
         s_q.por_pend      <= 1'b1;
         // accumulator and table pointer have no defined value here; zero is one
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs straight from flip-flops
   // read data and ack are registered, so each answer costs one cycle
   // ---------------------------------------------------------------
   assign WB_DAT_O         = s_q.dat;
   assign WB_ACK_O         = s_q.ack;
   assign CORE_RESET       = s_q.core_rst;
   assign PROGRAM_COUNTER  = s_q.pc;
   assign STACK_POINTER    = s_q.sp;
   assign INT_ENABLE       = s_q.int_en;
   assign TIMER_CTRL       = s_q.timer;
   assign PORT_A_DATA      = s_q.pa;
   assign PORT_A_DIRECTION = s_q.pa_dir;
   assign PORT_A_PULLUP    = s_q.pa_pu;
   assign IRQ              = s_q.irq;
endmodule
`default_nettype wire

// ---- logic/reset_state_map.svh ----
/*
 * Constants for the reset state controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 40 MHz system clock and a Wishbone register bus.
 */
`ifndef RESET_STATE_MAP_SVH
`define RESET_STATE_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define ADDR_STATUS     8'h00
`define ADDR_FLAGS      8'h04
`define ADDR_WDOG       8'h08
`define ADDR_IRQ_STAT   8'h0c
`define ADDR_IRQ_MASK   8'h10
`define ADDR_CTRL       8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define STATUS_PDF_BIT  4
`define STATUS_TO_BIT   5
`define FLAGS_LVR_BIT   2
`define FLAGS_WRF_BIT   0
`define CTRL_SLEEP_BIT  0
`define CTRL_KICK_BIT   1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WDOG_RESET      8'h53
`define WDOG_EN_A       5'h0a
`define WDOG_EN_B       5'h15
`define PORT_RESET      8'hff
`define PULLUP_RESET    8'h00
`define TIMER_RESET     8'h00
`define PC_RESET        13'h0000
`define SP_RESET        3'h0

// ---------------------------------------------------------------
// timing: times in ns, counts derived at 25 ns per cycle
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   25
`define RSTD_NS         1000
`define SST_NS          400
`define RSTD_CYC        ((`RSTD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SST_CYC         ((`SST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDOG_TO_CYC     4000

`endif

// ---- logic/reset_state_pkg.sv ----
/*
 * Types for the reset state controller.
 * Assumes the map header supplies all numbers.
 */
`default_nettype none
package reset_state_pkg;
   // kind of reset being applied
   typedef enum logic [2:0] {
      RK_NONE,
      RK_POWER_ON,
      RK_LOW_VOLT,
      RK_WDOG_RUN,
      RK_WDOG_SLEEP,
      RK_WDOG_WRITE
   } reset_kind_t;
   // sequencer states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_HOLD,
      ST_WAKE
   } seq_state_t;
endpackage
`default_nettype wire

// ---- logic/reset_delay_counter.sv ----
/*
 * Down counter that measures a reset hold or wake delay.
 * Assumes a synchronous active-high reset on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_delay_counter
   import reset_state_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // control
   input  wire logic        load,
   input  wire logic [15:0] count,
   // status
   output logic             busy
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cnt;
   } dly_state_t;
   dly_state_t s_q;
   dly_state_t s_d;

   // load wins over counting so a retrigger restarts the delay
   always_comb begin
      s_d = s_q;
      if (load) begin
         s_d.cnt = count;
      end else if (s_q.cnt != 16'h0000) begin
         s_d.cnt = s_q.cnt - 16'h0001;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = (s_q.cnt != 16'h0000);
endmodule
`default_nettype wire

// ---- logic/watchdog_core.sv ----
/*
 * Watchdog time-out counter with enable field check.
 * Assumes the controller clears it on every reset and kick.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_map.svh"
module watchdog_core
   import reset_state_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       clear,
   input  wire logic [4:0] enable_field,
   // events
   output logic            timeout,
   output logic            bad_enable
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cnt;
   } wd_state_t;
   wd_state_t s_q;
   wd_state_t s_d;

   // enable field decode, used by both the counter and the event
   function automatic logic field_ok(input logic [4:0] f);
      return (f == `WDOG_EN_A) || (f == `WDOG_EN_B);
   endfunction

   // count up while enabled, restart on clear or overflow
   always_comb begin
      s_d = s_q;
      if (clear || !field_ok(enable_field) || timeout) begin
         s_d.cnt = 16'h0000;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign timeout    = (s_q.cnt == 16'(`WDOG_TO_CYC - 1));
   assign bad_enable = !field_ok(enable_field);
endmodule
`default_nettype wire

// ---- verif/reset_state_controller_asserts.sv ----
/*
 * Port checker for the reset state controller.
 * Assumes it is bound to the top module, with one clock and RST as the
 * synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_state_controller_chk (
   // clock and reset
   input wire logic        MCLK,
   input wire logic        RST,
   // bus handshake
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_ACK_O,
   // core state
   input wire logic        CORE_RESET,
   input wire logic [12:0] PROGRAM_COUNTER,
   input wire logic [2:0]  STACK_POINTER,
   input wire logic        INT_ENABLE,
   input wire logic [7:0]  TIMER_CTRL,
   input wire logic [7:0]  PORT_A_DATA,
   input wire logic [7:0]  PORT_A_DIRECTION,
   input wire logic [7:0]  PORT_A_PULLUP
);
   // ----------------------------------------
   // one clock domain, reset masks everything
   // ----------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   // first cycle after power-on: presets must already be visible
   pc_clear_a: assert property ($fell(RST) |-> PROGRAM_COUNTER == 13'h0000 && STACK_POINTER == 3'h0)
      else $error("program counter or stack not zero after power-on");
   int_off_a: assert property ($fell(RST) |-> !INT_ENABLE)
      else $error("interrupts enabled after power-on");
   timer_off_a: assert property ($fell(RST) |-> TIMER_CTRL == 8'h00)
      else $error("timer control not cleared after power-on");
   port_input_a: assert property ($fell(RST) |-> PORT_A_DATA == 8'hff && PORT_A_DIRECTION == 8'hff
                                  && PORT_A_PULLUP == 8'h00)
      else $error("port presets wrong after power-on");
   // internal reset stays asserted for at least four cycles after the power-on pulse
   hold_delay_a: assert property ($fell(RST) |-> CORE_RESET [*4])
      else $error("internal reset released too early");
   // stack and counter stay at zero while the core is held
   held_pc_zero_a: assert property (CORE_RESET && $past(CORE_RESET)
                                    |-> PROGRAM_COUNTER == 13'h0000 && STACK_POINTER == 3'h0)
      else $error("counter or stack moved during internal reset");
   // bus answer comes one cycle after the taking edge, for one cycle
   bus_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not acknowledged in one cycle");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("acknowledge longer than one cycle");
endmodule

bind reset_state_controller reset_state_controller_chk i_chk (
   .MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
   .CORE_RESET(CORE_RESET), .PROGRAM_COUNTER(PROGRAM_COUNTER), .STACK_POINTER(STACK_POINTER),
   .INT_ENABLE(INT_ENABLE), .TIMER_CTRL(TIMER_CTRL), .PORT_A_DATA(PORT_A_DATA),
   .PORT_A_DIRECTION(PORT_A_DIRECTION), .PORT_A_PULLUP(PORT_A_PULLUP)
);
`default_nettype wire

// ---- verif/test_reset_state_controller.sv ----
/*
 * Self-checking bench for the reset state controller.
 * Assumes the map header and package compile first; the bench is the
 * only bus master and drives the low-voltage level itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_map.svh"
module test_reset_state_controller;
   import reset_state_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic        mclk = 0, rst = 1, low_volt = 0;
   logic        cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, q;
   logic        ack, core_rst, int_en, irq;
   logic [12:0] pc;
   logic [2:0]  sp;
   logic [7:0]  tmr, pa, pdir, ppu;
   int          n_fail = 0, check_count = 0;

   always #12.5 mclk = ~mclk;

   // short hold and wake counts keep the run brief
   reset_state_controller #(.RSTD_CYCLES(8), .SST_CYCLES(4)) i_dut (
      .MCLK(mclk), .RST(rst), .LOW_VOLTAGE(low_volt), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .CORE_RESET(core_rst), .PROGRAM_COUNTER(pc), .STACK_POINTER(sp), .INT_ENABLE(int_en),
      .TIMER_CTRL(tmr), .PORT_A_DATA(pa), .PORT_A_DIRECTION(pdir), .PORT_A_PULLUP(ppu), .IRQ(irq));

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // classic single cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1);
      q = dat_o;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // wait, bounded, until the internal reset is released
   task automatic wait_run();
      int n;
      for (n = 0; n < 100 && core_rst !== 1'b0; n++) @(posedge mclk);
      chk(core_rst, 1'b0);
   endtask

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic t_power_on();
      chk(core_rst, 1'b1);
      chk({pc, sp, int_en}, 17'h0);
      chk({tmr, pa, pdir, ppu}, 32'h00ffff00);
      wait_run();
      rd(`ADDR_STATUS, 32'h0);
      rd(`ADDR_WDOG, 32'h53);
      rd(8'h40, 32'h0);
   endtask

   // no kicks: the watchdog overflows during normal running
   task automatic t_run_wdog();
      int n;
      for (n = 0; n < 5000 && core_rst !== 1'b1; n++) @(posedge mclk);
      chk(core_rst, 1'b1);
      chk(pc, 13'h0000);
      wait_run();
      rd(`ADDR_STATUS, 32'h20);
      rd(`ADDR_WDOG, 32'h53);
      chk({tmr, pa, pdir, ppu}, 32'h00ffff00);
   endtask

   // low-voltage reset keeps status flags, sets its own flag and event
   task automatic t_low_volt();
      logic i1, i0;
      wb(1'b1, `ADDR_IRQ_STAT, 32'h03);
      low_volt <= 1;
      repeat (3) @(posedge mclk);
      low_volt <= 0;
      @(posedge mclk);
      chk(pc, 13'h0000);
      wait_run();
      rd(`ADDR_STATUS, 32'h20);
      rd(`ADDR_FLAGS, 32'h04);
      wb(1'b1, `ADDR_IRQ_MASK, 32'h04);
      i1 = irq;
      wb(1'b1, `ADDR_IRQ_MASK, 32'h00);
      i0 = irq;
      chk({i1, i0}, 2'b10);
      wb(1'b1, `ADDR_IRQ_STAT, 32'h04);
      wb(1'b1, `ADDR_IRQ_MASK, 32'h04);
      chk(irq, 1'b0);
      wb(1'b1, `ADDR_FLAGS, 32'h00);
      rd(`ADDR_FLAGS, 32'h0);
   endtask

   // sleep: low voltage ignored, watchdog wake sets both flags
   task automatic t_sleep();
      int n;
      wb(1'b1, `ADDR_IRQ_STAT, 32'h07);
      wb(1'b1, `ADDR_CTRL, 32'h01);
      rd(`ADDR_STATUS, 32'h30);
      low_volt <= 1;
      repeat (3) @(posedge mclk);
      low_volt <= 0;
      rd(`ADDR_FLAGS, 32'h0);
      for (n = 0; n < 6000 && core_rst !== 1'b1; n++) @(posedge mclk);
      chk({pc, sp}, 16'h0);
      repeat (3) @(posedge mclk);
      chk(core_rst, 1'b1);
      wait_run();
      rd(`ADDR_IRQ_STAT, 32'h1);
      rd(`ADDR_STATUS, 32'h30);
   endtask

   // a bad enable field triggers a software reset and its flag
   task automatic t_bad_enable();
      wb(1'b1, `ADDR_WDOG, 32'h00);
      repeat (3) @(posedge mclk);
      chk(pc, 13'h0000);
      wait_run();
      rd(`ADDR_FLAGS, 32'h01);
      wb(1'b1, `ADDR_FLAGS, 32'h00);
      wb(1'b1, `ADDR_WDOG, 32'hab);
      repeat (3) @(posedge mclk);
      rd(`ADDR_FLAGS, 32'h0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      t_power_on();
      t_run_wdog();
      t_low_volt();
      t_sleep();
      t_bad_enable();
      final_report();
   end

   // hang guard, well beyond three watchdog periods
   initial begin
      #(25 * 40000);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
